// *** verilog/sacpc_pkg.sv ***
// Package: constants and carrier types for the converter start/power control
package sacpc_pkg;

   // Clock rate in kHz (25 MHz)
   localparam int CLK_KHZ          = 25000;
   // Internal power-up pulse, nanoseconds
   localparam int PWRUP_NS         = 1500;
   localparam int PWRUP_CYCLES     = (PWRUP_NS * CLK_KHZ + 999999) / 1000000;
   // Conversion time, nanoseconds
   localparam int CONV_NS          = 4500;
   localparam int CONV_CYCLES      = (CONV_NS * CLK_KHZ) / 1000000;
   // Result width and successive-approximation step length in cycles
   localparam int RES_BITS         = 8;
   localparam int STEP_CYCLES      = CONV_CYCLES / RES_BITS;
   // Reset values
   localparam logic [7:0] RESULT_RST = 8'h00;

   // Converter phases
   typedef enum logic [1:0] {
      SACPC_PWRDN,
      SACPC_TRACK,
      SACPC_CONVERT
   } sacpc_state_t;

   // Status carried to the pins
   typedef struct packed {
      logic       busy;
      logic       powered;
      logic       hold;
      logic       fast_mode;
   } sacpc_status_t;

   // Comparator/DAC step interface
   typedef struct packed {
      logic [7:0] trial;
      logic       sample;
   } sacpc_dac_t;

endpackage

// *** verilog/sacpc_sar.sv ***
// Successive-approximation register stepping the trial code
`timescale 1ns/1ps
`default_nettype none
module sacpc_sar
(
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       start,
   input  wire logic       step,
   input  wire logic       comp_high,
   output logic [7:0]      trial,
   output logic [7:0]      result,
   output logic            done
);

   logic [7:0] bitmask;
   logic [7:0] next_trial;
   logic [7:0] next_bitmask;
   logic [7:0] next_result;
   logic       next_done;

   // Next trial code: keep or drop current bit, try the next one
   always_comb
   begin
      next_trial   = trial;
      next_bitmask = bitmask;
      next_result  = result;
      next_done    = 1'b0;
      if (start)
      begin
         next_trial   = 8'h80;
         next_bitmask = 8'h80;
      end
      else if (step && bitmask != 8'h00)
      begin
         next_bitmask = bitmask >> 1;
         if (comp_high)
            next_trial = (trial & ~bitmask) | (bitmask >> 1);
         else
            next_trial = trial | (bitmask >> 1);
         if (bitmask == 8'h01)
         begin
            // Rebalanced: form the output code
            next_result = comp_high ? (trial & ~bitmask) : trial;
            next_done   = 1'b1;
         end
      end
   end

   // Register stage
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         trial   <= 8'h00;
         bitmask <= 8'h00;
         result  <= sacpc_pkg::RESULT_RST;
         done    <= 1'b0;
      end
      else
      begin
         trial   <= next_trial;
         bitmask <= next_bitmask;
         result  <= next_result;
         done    <= next_done;
      end
   end

endmodule
`default_nettype wire

// *** verilog/sacpc_ctrl.sv ***
// Conversion-start and power control for an 8-bit SAR converter
//
// Overview of operation
// - After supply, sit powered down until a start rising edge.
// - Start-pin rising edge fires a 1.5 us internal power-up pulse.
// - Leave power-down on the internal pulse's rising edge.
// - Convert only on the falling edge of the gated start.
// - Gated start is internal pulse OR external start level.
// - Busy high during conversion; its falling edge marks the end.
// - Track after conversion if start is high at busy fall; hold at the next gated start fall.
// - Conversion steps a DAC by successive approximation, then codes.
// - Start pin high at busy fall keeps power; low powers down.
// - Auto power-down mode sleeps after each conversion, wakes before next.
// - Result is straight binary, 1 LSB equals reference over 256.
`timescale 1ns/1ps
`default_nettype none
module sacpc_ctrl
(
   input  wire logic                clk,
   input  wire logic                nrst,
   input  wire logic                conversion_start_n,
   input  wire logic                comp_high,
   output sacpc_pkg::sacpc_status_t status,
   output sacpc_pkg::sacpc_dac_t    dac,
   output logic [7:0]               result,
   output logic                     busy
);

   // ****************************************************
   // Input synchronisation
   // ****************************************************
   logic start_meta;
   logic start_sync;
   logic start_prev;

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         start_meta <= 1'b0;
         start_sync <= 1'b0;
         start_prev <= 1'b0;
      end
      else
      begin
         start_meta <= conversion_start_n;
         start_sync <= start_meta;
         start_prev <= start_sync;
      end
   end

   logic start_rise;
   assign start_rise = start_sync & ~start_prev;

   // ****************************************************
   // Power-up pulse and gated start
   // ****************************************************
   logic [7:0] pulse_cnt;
   logic [7:0] next_pulse_cnt;
   logic       int_pulse;
   logic       next_int_pulse;
   logic       gated;
   logic       gated_prev;
   logic       gated_fall;
   logic       pulse_prev;

   // Pulse timer restarts on each start rising edge
   always_comb
   begin
      next_pulse_cnt = pulse_cnt;
      next_int_pulse = int_pulse;
      if (start_rise)
      begin
         next_pulse_cnt = 8'(sacpc_pkg::PWRUP_CYCLES - 1);
         next_int_pulse = 1'b1;
      end
      else if (pulse_cnt != 8'h00)
         next_pulse_cnt = pulse_cnt - 8'h01;
      else
         next_int_pulse = 1'b0;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pulse_cnt  <= 8'h00;
         int_pulse  <= 1'b0;
         gated_prev <= 1'b0;
         pulse_prev <= 1'b0;
      end
      else
      begin
         pulse_cnt  <= next_pulse_cnt;
         int_pulse  <= next_int_pulse;
         gated_prev <= gated;
         pulse_prev <= int_pulse;                       // Pulse edge detect
      end
   end

   assign gated      = int_pulse | start_sync;
   assign gated_fall = gated_prev & ~gated;

   // ****************************************************
   // Phase control
   // ****************************************************
   sacpc_pkg::sacpc_state_t state;
   sacpc_pkg::sacpc_state_t next_state;
   logic [7:0] step_cnt;
   logic [7:0] next_step_cnt;
   logic       powered;
   logic       next_powered;
   logic       fast_mode;
   logic       next_fast_mode;
   logic       sar_start;
   logic       sar_step;
   logic       sar_done;
   logic [7:0] sar_trial;
   logic [7:0] sar_result;

   // Next phase, power and step timing
   always_comb
   begin
      next_state     = state;
      next_step_cnt  = step_cnt;
      next_powered   = powered;
      next_fast_mode = fast_mode;
      sar_start      = 1'b0;
      sar_step       = 1'b0;
      case (state)
         sacpc_pkg::SACPC_PWRDN:
         begin
            if (int_pulse && !pulse_prev)
            begin
               next_powered = 1'b1;
               next_state   = sacpc_pkg::SACPC_TRACK;
            end
         end
         sacpc_pkg::SACPC_TRACK:
         begin
            if (gated_fall)
            begin
               sar_start     = 1'b1;
               next_step_cnt = 8'(sacpc_pkg::STEP_CYCLES - 1);
               next_state    = sacpc_pkg::SACPC_CONVERT;
            end
         end
         sacpc_pkg::SACPC_CONVERT:
         begin
            if (step_cnt != 8'h00)
               next_step_cnt = step_cnt - 8'h01;
            else
            begin
               sar_step      = 1'b1;
               next_step_cnt = 8'(sacpc_pkg::STEP_CYCLES - 1);
            end
            if (sar_done)
            begin
               next_fast_mode = start_sync;
               if (start_sync)
                  next_state = sacpc_pkg::SACPC_TRACK;
               else
               begin
                  next_powered = 1'b0;
                  next_state   = sacpc_pkg::SACPC_PWRDN;
               end
            end
         end
         default:
            next_state = sacpc_pkg::SACPC_PWRDN;
      endcase
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state     <= sacpc_pkg::SACPC_PWRDN;
         step_cnt  <= 8'h00;
         powered   <= 1'b0;
         fast_mode <= 1'b0;
      end
      else
      begin
         state     <= next_state;
         step_cnt  <= next_step_cnt;
         powered   <= next_powered;
         fast_mode <= next_fast_mode;
      end
   end

   // Successive-approximation engine
   sacpc_sar u_sar
   (
      .clk       (clk),
      .nrst      (nrst),
      .start     (sar_start),
      .step      (sar_step),
      .comp_high (comp_high),
      .trial     (sar_trial),
      .result    (sar_result),
      .done      (sar_done)
   );

   // ****************************************************
   // Registered outputs
   // ****************************************************
   sacpc_pkg::sacpc_status_t next_status;
   sacpc_pkg::sacpc_dac_t    next_dac;
   logic                     next_busy;

   always_comb
   begin
      next_busy             = (next_state == sacpc_pkg::SACPC_CONVERT);
      next_status.busy      = next_busy;
      next_status.powered   = next_powered;
      next_status.hold      = next_busy;
      next_status.fast_mode = next_fast_mode;
      next_dac.trial        = sar_trial;
      next_dac.sample       = (next_state == sacpc_pkg::SACPC_TRACK);
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         busy   <= 1'b0;
         status <= '0;
         dac    <= '0;
         result <= sacpc_pkg::RESULT_RST;
      end
      else
      begin
         busy   <= next_busy;
         status <= next_status;
         dac    <= next_dac;
         result <= sar_result;
      end
   end

endmodule
`default_nettype wire

// *** sim/sacpc_monitor.sv ***
// Checker for converter start and power control
`timescale 1ns/1ps
`default_nettype none
module sacpc_monitor
(
   input wire logic                     clk,
   input wire logic                     nrst,
   input wire logic                     conversion_start_n,
   input wire logic                     comp_high,
   input wire sacpc_pkg::sacpc_status_t status,
   input wire sacpc_pkg::sacpc_dac_t    dac,
   input wire logic [7:0]               result,
   input wire logic                     busy
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   // ****************************************
   // Power and conversion checks
   // ****************************************
   sequence s_wake;
      !status.powered ##1 status.powered;
   endsequence
   sequence s_conv;
      $rose(busy) ##100 busy;
   endsequence
   property p_wake;
      $rose(conversion_start_n) && !status.powered |-> ##[1:8] status.powered;
   endproperty
   property p_gap;
      s_wake |-> !busy [*8];
   endproperty
   property p_len;
      s_conv |-> ##[1:25] !busy;
   endproperty
   property p_flag;
      busy == status.busy && busy == status.hold;
   endproperty
   property p_hold;
      busy |-> status.powered && !dac.sample;
   endproperty
   property p_res;
      !busy && !$fell(busy) |-> $stable(result);
   endproperty
   property p_start;
      $rose(busy) |-> $past(status.powered, 2);
   endproperty
   property p_mode;
      $fell(busy) |-> ##2 status.powered == status.fast_mode;
   endproperty
   a_wake: assert property (p_wake)
      else $error("no power-up after start rise");
   a_gap: assert property (p_gap)
      else $error("conversion inside power-up pulse");
   a_len: assert property (p_len)
      else $error("busy length wrong");
   a_flag: assert property (p_flag)
      else $error("busy flags differ");
   a_hold: assert property (p_hold)
      else $error("no hold while busy");
   a_res: assert property (p_res)
      else $error("result moved outside end of conversion");
   a_start: assert property (p_start)
      else $error("conversion while powered down");
   a_mode: assert property (p_mode)
      else $error("mode and power disagree");
endmodule
`default_nettype wire

// *** sim/sacpc_comp_model.sv ***
// Comparator model holding the sampled input level
`timescale 1ns/1ps
`default_nettype none
module sacpc_comp_model
(
   input  wire logic                  clk,
   input  wire sacpc_pkg::sacpc_dac_t dac,
   input  wire logic [7:0]            analog_sample_input,
   output logic                       comp_high
);
   logic [7:0] held = 8'h00;
   // Track while sampling, hold during conversion
   always_ff @(posedge clk)
   begin
      if (dac.sample)
         held <= analog_sample_input;
   end
   // Trial above held level drops the bit
   assign comp_high = dac.trial > held;
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// Testbench for converter start and power control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic                     clk = 1'b0;
   logic                     nrst = 1'b0;
   logic                     conversion_start_n = 1'b0;
   logic [7:0]               level = 8'h00;
   logic                     comp_high;
   sacpc_pkg::sacpc_status_t status;
   sacpc_pkg::sacpc_dac_t    dac;
   logic [7:0]               result;
   logic                     busy;
   int                       bad_count = 0;
   int                       compares = 0;
   int                       cycles = 0;
   int                       n;
   always #20 clk = ~clk;
   sacpc_ctrl sacpc_ctrl_i (.clk(clk), .nrst(nrst),
      .conversion_start_n(conversion_start_n), .comp_high(comp_high),
      .status(status), .dac(dac), .result(result), .busy(busy));
   sacpc_comp_model sacpc_comp_model_i (.clk(clk), .dac(dac),
      .analog_sample_input(level), .comp_high(comp_high));
   // ****************************************
   // Helpers
   // ****************************************
   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test;
      if (bad_count == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Cycle ceiling
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         bad_count++;
         stop_test();
      end
   end
   task automatic tick(int k);
      repeat (k) @(negedge clk);
   endtask
   // Bounded wait for busy level
   task automatic wait_busy(logic v, output int k);
      k = 0;
      while (busy !== v && k < 400)
      begin
         @(negedge clk);
         k++;
      end
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_idle;
      tick(50);
      check("powered", status.powered, 8'h00);
      check("busy", busy, 8'h00);
   endtask
   // Power-down mode with a start pulse of hi cycles
   task automatic t_auto(logic [7:0] lv, int hi);
      int m;
      level = lv;
      conversion_start_n = 1'b1;
      tick(hi);
      conversion_start_n = 1'b0;
      wait_busy(1'b1, n);
      m = (hi > 38) ? hi : 38;
      check("start", (hi + n > m) && (hi + n <= m + 10), 8'h01);
      wait_busy(1'b0, n);
      check("length", (n >= 110) && (n <= 122), 8'h01);
      check("result", result, lv);
      tick(3);
      check("asleep", status.powered, 8'h00);
      tick(5);
   endtask
   // Fast mode followed by a power-down end
   task automatic t_fast(logic [7:0] a, logic [7:0] b);
      level = a;
      conversion_start_n = 1'b1;
      tick(5);
      conversion_start_n = 1'b0;
      wait_busy(1'b1, n);
      tick(10);
      conversion_start_n = 1'b1;
      wait_busy(1'b0, n);
      check("result", result, a);
      tick(3);
      check("fast", {status.fast_mode, status.powered}, 8'h03);
      check("sample", dac.sample, 8'h01);
      level = b;
      tick(5);
      conversion_start_n = 1'b0;
      wait_busy(1'b1, n);
      check("quick", n <= 6, 8'h01);
      wait_busy(1'b0, n);
      check("result", result, b);
      tick(3);
      check("asleep", status.powered, 8'h00);
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      tick(8);
      nrst = 1'b1;
      t_idle();
      t_auto(8'h00, 5);
      t_auto(8'hFF, 80);
      t_auto(8'hA5, 5);
      t_auto(8'h5A, 80);
      t_auto(8'h80, 38);
      t_fast(8'h3C, 8'hC3);
      stop_test();
   end
endmodule
bind sacpc_ctrl sacpc_monitor sacpc_monitor_i (.clk(clk), .nrst(nrst),
   .conversion_start_n(conversion_start_n), .comp_high(comp_high),
   .status(status), .dac(dac), .result(result), .busy(busy));
`default_nettype wire
